//--- core/descriptor_store.sv
`timescale 1ns/100ps
`include "segment_protect_extend_consts.svh"
module descriptor_store #(
    parameter int NUM_SEG = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // write side, word index: bit 0 selects high word
    input wire logic wrEn,
    input wire logic [4:0] wrIdx,
    input wire logic [31:0] wrData,
    input wire logic [3:0] wrBe,
    // registered read side
    input wire logic rdEn,
    input wire logic [4:0] rdIdx,
    output segment_protect_extend_pkg::word_t rdData,
    // all descriptors for the parallel matcher
    output segment_protect_extend_pkg::word_t highWord [NUM_SEG],
    output segment_protect_extend_pkg::word_t lowWord [NUM_SEG]
);
    // descriptor words with their reset presets
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < NUM_SEG; i++)
            begin
                highWord[i] <= `SPE_ZERO_WORD;
                lowWord[i] <= `SPE_ZERO_WORD;
            end
            highWord[0] <= `SPE_SEG0_HIGH;
            lowWord[0] <= `SPE_SEG0_LOW;
            highWord[1] <= `SPE_SEG1_HIGH;
            lowWord[1] <= `SPE_SEG1_LOW;
        end
        else if (wrEn)
        begin
            // byte lanes honoured per Avalon byteenable
            for (int b = 0; b < 4; b++)
            begin
                if (wrBe[b] && wrIdx[0])
                    highWord[wrIdx[4:1]][b*8 +: 8] <= wrData[b*8 +: 8];
                else if (wrBe[b])
                    lowWord[wrIdx[4:1]][b*8 +: 8] <= wrData[b*8 +: 8];
            end
        end
    end

    // read data come out of a register
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdData <= `SPE_ZERO_WORD;
        else if (rdEn && rdIdx[0])
            rdData <= highWord[rdIdx[4:1]];
        else if (rdEn)
            rdData <= lowWord[rdIdx[4:1]];
    end
endmodule

//--- core/segment_protect_extend.sv
`timescale 1ns/100ps
`include "segment_protect_extend_consts.svh"
module segment_protect_extend #(
    parameter int NUM_SEG = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // avalon-mm register slave
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // access request from core and caches
    input wire logic accReq,
    input wire logic [31:0] accAddr,
    input wire logic accWrite,
    input wire logic accExec,
    input wire logic accSuper,
    // access answer, one cycle after the request
    output logic accValid,
    output logic accAllow,
    output logic accFault,
    output logic [35:0] physAddr,
    output logic [5:0] accPerm,
    // fault exception pulse and interrupt level
    output logic faultExc,
    output logic irq
);
    // bus slave state
    segment_protect_extend_pkg::bus_state_t busState;
    // descriptor words seen by the matcher
    segment_protect_extend_pkg::word_t highWord [NUM_SEG];
    segment_protect_extend_pkg::word_t lowWord [NUM_SEG];
    // registered store read data
    segment_protect_extend_pkg::word_t storeRd;
    // fault record
    logic [31:0] faultAddr;
    logic [31:0] faultStat;
    logic faultHeld;
    // interrupt status and mask
    logic irqStat;
    logic irqMask;
    // combinational match results
    logic hit;
    logic [3:0] hitIdx;
    logic [5:0] segPerm;
    logic [2:0] needBit;
    logic ctrlSpace;
    logic allowed;
    logic [35:0] next_physAddr;
    // bus strobes
    logic busWrDone;
    logic clearNow;
    logic faultNew;
    logic captureNow;

    // upper-bit mask of a segment: ones where the base is compared
    function automatic logic [31:0] segMask(input logic [4:0] code);
        logic [32:0] span;
        span = 33'h0_0000_0000;
        span = 33'h0_0000_0001 << (code + 5'h01);
        segMask = ~(span[31:0] - 32'h0000_0001);
        if (code == 5'h1f)
            segMask = 32'h0000_0000;
    endfunction

    // a segment is enabled only at or above the smallest size code
    function automatic logic segOn(input logic [4:0] code);
        segOn = (code >= `SPE_SIZE_MIN);
    endfunction

    // descriptor word space decode
    function automatic logic isDesc(input logic [31:0] a);
        isDesc = (a >= `SPE_DESC_FIRST) && (a <= `SPE_DESC_LAST);
    endfunction

    // permission bit index from privilege and access kind
    function automatic logic [2:0] permIndex(input logic sup, input logic wr,
                                             input logic ex);
        logic [2:0] kind;
        kind = 3'h2;
        if (ex)
            kind = 3'h0;
        else if (wr)
            kind = 3'h1;
        permIndex = sup ? kind + `SPE_SUP_GROUP : kind;
    endfunction

    // descriptor storage
    descriptor_store #(
        .NUM_SEG(NUM_SEG)
    ) descriptor_store_i (
        .clk(clk),
        .sys_rst(sys_rst),
        .wrEn(busWrDone && isDesc(avs_address)),
        .wrIdx(avs_address[6:2]),
        .wrData(avs_writedata),
        .wrBe(avs_byteenable),
        .rdEn(busState == segment_protect_extend_pkg::BUS_IDLE && avs_read),
        .rdIdx(avs_address[6:2]),
        .rdData(storeRd),
        .highWord(highWord),
        .lowWord(lowWord)
    );

    // parallel segment match, later index overrides earlier
    always_comb
    begin
        hit = 1'b0;
        hitIdx = 4'h0;
        for (int i = 0; i < NUM_SEG; i++)
        begin
            // base compared on the bits above the segment size
            if (segOn(highWord[i][`SPE_SIZE_MSB:0]) &&
                ((accAddr & segMask(highWord[i][`SPE_SIZE_MSB:0])) ==
                 ({highWord[i][31:`SPE_BASE_LSB], 12'h000} &
                  segMask(highWord[i][`SPE_SIZE_MSB:0]))))
            begin
                hit = 1'b1;
                hitIdx = i[3:0];
            end
        end
    end

    // permission check and address extension
    always_comb
    begin
        logic [31:0] m;
        logic [35:0] repl;
        m = segMask(highWord[hitIdx][`SPE_SIZE_MSB:0]);
        repl = {lowWord[hitIdx][31:`SPE_REPL_LSB], 12'h000};
        ctrlSpace = (accAddr < `SPE_CTRL_LIMIT);
        // no hit reads as a segment with no permissions
        segPerm = hit ? lowWord[hitIdx][`SPE_PERMISSION_FIELD_USED:0] : 6'h00;
        needBit = permIndex(accSuper, accWrite, accExec);
        allowed = ctrlSpace || segPerm[needBit];
        // matched upper bits replaced, the rest pass through
        next_physAddr = (repl & {4'hf, m}) | {4'h0, accAddr & ~m};
        if (ctrlSpace)
            next_physAddr = {4'h0, accAddr};
    end

    // access answer registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            accValid <= 1'b0;
            accAllow <= 1'b0;
            accFault <= 1'b0;
            physAddr <= 36'h0_0000_0000;
            accPerm <= 6'h00;
        end
        else
        begin
            accValid <= accReq;
            accAllow <= accReq && allowed;
            accFault <= accReq && !allowed;
            // refused accesses show no physical address
            physAddr <= (accReq && allowed) ? next_physAddr : 36'h0_0000_0000;
            accPerm <= accReq ? segPerm : 6'h00;
        end
    end

    // bus strobes at the completing edge
    assign busWrDone = avs_write && !avs_waitrequest;
    assign clearNow = busWrDone && (avs_address == `SPE_FAULT_CLR) &&
                      avs_byteenable[0] && avs_writedata[`SPE_CLR_BIT];
    assign faultNew = accReq && !allowed;
    // a new fault in the clear cycle is captured: set wins
    assign captureNow = faultNew && (!faultHeld || clearNow);

    // fault record, first fault only
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            faultHeld <= 1'b0;
            faultAddr <= `SPE_ZERO_WORD;
            faultStat <= `SPE_ZERO_WORD;
            faultExc <= 1'b0;
        end
        else
        begin
            faultExc <= captureNow;
            if (captureNow)
            begin
                faultHeld <= 1'b1;
                faultAddr <= accAddr;
                // access type as a one-hot of the missing flag
                faultStat <= 32'h0000_0001 << needBit;
            end
            else if (clearNow)
            begin
                faultHeld <= 1'b0;
                faultAddr <= `SPE_ZERO_WORD;
                faultStat <= `SPE_ZERO_WORD;
            end
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irqStat <= 1'b0;
            irqMask <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            if (captureNow)
                irqStat <= 1'b1;
            else if (busWrDone && avs_address == `SPE_IRQ_STAT &&
                     avs_byteenable[0] && avs_writedata[0])
                irqStat <= 1'b0;
            if (busWrDone && avs_address == `SPE_IRQ_MASK && avs_byteenable[0])
                irqMask <= avs_writedata[0];
            irq <= (irqStat || captureNow) && irqMask;
        end
    end

    // avalon slave: idle, fetch, answer with waitrequest low
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busState <= segment_protect_extend_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= `SPE_ZERO_WORD;
        end
        else
        begin
            case (busState)
                segment_protect_extend_pkg::BUS_IDLE:
                begin
                    // request seen, store read launched
                    if (avs_read || avs_write)
                        busState <= segment_protect_extend_pkg::BUS_FETCH;
                end
                segment_protect_extend_pkg::BUS_FETCH:
                begin
                    avs_waitrequest <= 1'b0;
                    busState <= segment_protect_extend_pkg::BUS_ANSWER;
                    // read mux, unmapped addresses read zero
                    if (!avs_read)
                        avs_readdata <= `SPE_ZERO_WORD;
                    else if (isDesc(avs_address))
                        avs_readdata <= storeRd;
                    else if (avs_address == `SPE_FAULT_ADDR)
                        avs_readdata <= faultAddr;
                    else if (avs_address == `SPE_FAULT_STAT)
                        avs_readdata <= faultStat;
                    else if (avs_address == `SPE_IRQ_STAT)
                        avs_readdata <= {31'h0000_0000, irqStat};
                    else if (avs_address == `SPE_IRQ_MASK)
                        avs_readdata <= {31'h0000_0000, irqMask};
                    else
                        avs_readdata <= `SPE_ZERO_WORD;
                end
                segment_protect_extend_pkg::BUS_ANSWER:
                begin
                    // transfer completes at this edge
                    avs_waitrequest <= 1'b1;
                    busState <= segment_protect_extend_pkg::BUS_IDLE;
                end
                default:
                begin
                    avs_waitrequest <= 1'b1;
                    busState <= segment_protect_extend_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // bus request held from idle through the answer
    // waitrequest is registered: it reads low only at the second edge after the take
    sequence s_req_start;
        (avs_read || avs_write) && busState == segment_protect_extend_pkg::BUS_IDLE;
    endsequence
    sequence s_answer;
        avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_bus_answer_timing: assert property (@(posedge clk) disable iff (sys_rst)
        s_req_start |-> s_answer)
        else $error("bus answer not two cycles after request");

    // an access outside every enabled segment and outside the control space is refused
    a_nohit_refused: assert property (@(posedge clk) disable iff (sys_rst)
        accReq && !hit && !ctrlSpace |=> accFault && !accAllow)
        else $error("unmatched access was not refused");

    // user read follows the user read flag of the chosen segment
    a_user_flag_check: assert property (@(posedge clk) disable iff (sys_rst)
        accReq && !accSuper && !ctrlSpace && hit && !accWrite && !accExec
        |=> accAllow == $past(lowWord[hitIdx][2]))
        else $error("user read decision wrong");

    // supervisor write follows the supervisor write flag
    a_sup_flag_check: assert property (@(posedge clk) disable iff (sys_rst)
        accReq && accSuper && !ctrlSpace && hit && accWrite && !accExec
        |=> accAllow == $past(lowWord[hitIdx][4]))
        else $error("supervisor write decision wrong");

    // a held record only changes through the clear bit
    a_fault_held: assert property (@(posedge clk) disable iff (sys_rst)
        faultHeld && !clearNow |=> $stable(faultAddr) && faultHeld)
        else $error("fault record changed while held");

    // exception pulses once for the captured fault; a second pulse needs a clear
    a_fault_exc_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        faultNew && !faultHeld |=> faultExc && faultHeld ##1 (!faultExc || $past(clearNow)))
        else $error("fault exception not raised once");

    // the page offset is never replaced
    a_low_bits_pass: assert property (@(posedge clk) disable iff (sys_rst)
        accReq && allowed |=> physAddr[11:0] == $past(accAddr[11:0]))
        else $error("page offset not passed through");

    // a segment below the smallest size code never matches
    a_disabled_no_hit: assert property (@(posedge clk) disable iff (sys_rst)
        hit |-> highWord[hitIdx][`SPE_SIZE_MSB:0] >= `SPE_SIZE_MIN)
        else $error("disabled segment matched");

    // unmasked status drives the interrupt level
    a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
        irqStat && irqMask |=> irq)
        else $error("interrupt not raised for unmasked status");

    // every request is answered once, either allowed or refused
    a_answer_follows: assert property (@(posedge clk) disable iff (sys_rst)
        accReq |=> accValid && (accAllow != accFault))
        else $error("access answer missing or ambiguous");

    // control register space passes zero-extended and is never refused
    a_ctrl_bypass: assert property (@(posedge clk) disable iff (sys_rst)
        accReq && ctrlSpace |=> accAllow && physAddr == {4'h0, $past(accAddr)})
        else $error("control space access not passed through");
endmodule

//--- core/segment_protect_extend_consts.svh
`ifndef SEGMENT_PROTECT_EXTEND_CONSTS_SVH
`define SEGMENT_PROTECT_EXTEND_CONSTS_SVH

// register byte addresses
`define SPE_DESC_FIRST 32'h0800_0000
`define SPE_DESC_LAST 32'h0800_007c
`define SPE_FAULT_ADDR 32'h0800_0200
`define SPE_FAULT_STAT 32'h0800_0204
`define SPE_FAULT_CLR 32'h0800_0208
`define SPE_IRQ_STAT 32'h0800_0210
`define SPE_IRQ_MASK 32'h0800_0214

// logical addresses below this are control registers, never checked
`define SPE_CTRL_LIMIT 32'h0c00_0000

// descriptor field positions
`define SPE_BASE_LSB 12
`define SPE_SIZE_MSB 4
`define SPE_REPL_LSB 8
`define SPE_PERMISSION_FIELD_MSB 7
`define SPE_PERMISSION_FIELD_USED 5
`define SPE_SIZE_MIN 5'h0b
`define SPE_LOCAL_BIT 8
`define SPE_CLR_BIT 0
`define SPE_SUP_GROUP 3'h3

// reset descriptor values
`define SPE_SEG0_HIGH 32'h0000_001e
`define SPE_SEG0_LOW 32'h0000_003f
`define SPE_SEG1_HIGH 32'h8000_001e
`define SPE_SEG1_LOW 32'h0800_003f
`define SPE_ZERO_WORD 32'h0000_0000

`endif

//--- core/segment_protect_extend_pkg.sv
package segment_protect_extend_pkg;
    // register bus slave phases
    typedef enum {BUS_IDLE, BUS_FETCH, BUS_ANSWER} bus_state_t;
    // one descriptor word
    typedef logic [31:0] word_t;
endpackage

//--- tb/core_access_model.sv
`timescale 1ns/100ps
module core_access_model (
    // clock
    input wire logic clk,
    // access request toward the unit
    output logic accReq,
    output logic [31:0] accAddr,
    output logic accWrite,
    output logic accExec,
    output logic accSuper
);
    // quiet bus at time zero
    initial
    begin
        accReq = 1'b0;
        accAddr = 32'h0000_0000;
        accWrite = 1'b0;
        accExec = 1'b0;
        accSuper = 1'b0;
    end
    // one access held for one cycle; afterwards the address shows junk, not the old value
    task automatic issue(input logic [31:0] a, input logic w, x, s);
        @(posedge clk);
        accReq <= 1'b1;
        accAddr <= a;
        accWrite <= w;
        accExec <= x;
        accSuper <= s;
        @(posedge clk);
        accReq <= 1'b0;
        accAddr <= ~a;
    endtask
endmodule

//--- tb/segment_protect_extend_tb_top.sv
`timescale 1ns/100ps
`include "segment_protect_extend_consts.svh"
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin failCount++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
module segment_protect_extend_tb_top;
    // clock, reset, register bus
    logic clk, sysRst, avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_address, avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    // access port
    logic accReq, accWrite, accExec, accSuper, accValid, accAllow, accFault, faultExc, irq;
    logic [31:0] accAddr;
    logic [35:0] physAddr;
    logic [5:0] accPerm;
    // reference model state
    logic [31:0] hi [16];
    logic [31:0] lo [16];
    logic [31:0] fAddr, fStat;
    logic held, iStat, iMask;
    int failCount, nCompared, cyc;

    segment_protect_extend segment_protect_extend_i (.clk(clk), .sys_rst(sysRst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .accReq(accReq), .accAddr(accAddr), .accWrite(accWrite), .accExec(accExec),
        .accSuper(accSuper), .accValid(accValid), .accAllow(accAllow),
        .accFault(accFault), .physAddr(physAddr), .accPerm(accPerm),
        .faultExc(faultExc), .irq(irq));
    core_access_model core_access_model_i (.clk(clk), .accReq(accReq), .accAddr(accAddr),
        .accWrite(accWrite), .accExec(accExec), .accSuper(accSuper));

    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            failCount++;
            wrap_up();
        end
    end
    // counts and verdict
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one bus cycle: hold until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [31:0] a, d, input logic [3:0] be,
        output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // register write, mirrored in the model
    task automatic wreg(input logic [31:0] a, d, input logic [3:0] be = 4'hf);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
        if (a >= `SPE_DESC_FIRST && a <= `SPE_DESC_LAST)
            for (int j = 0; j < 4; j++)
                if (be[j] && a[2]) hi[a[6:3]][8 * j +: 8] = d[8 * j +: 8];
                else if (be[j]) lo[a[6:3]][8 * j +: 8] = d[8 * j +: 8];
        if (a == `SPE_FAULT_CLR && d[0])
        begin
            held = 1'b0;
            fAddr = 32'h0;
            fStat = 32'h0;
        end
        if (a == `SPE_IRQ_STAT && d[0]) iStat = 1'b0;
        if (a == `SPE_IRQ_MASK) iMask = d[0];
    endtask
    // register read compared with an expectation
    task automatic rchk(input logic [31:0] a, e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        `CHK(q, e)
    endtask
    // one access: model predicts, then the answer is compared one cycle later
    task automatic acc(input logic [31:0] a, input logic w, x, s);
        int win, n, sh, b;
        logic [5:0] pm;
        logic ok, byp, exc;
        logic [35:0] p;
        win = -1;
        n = 99;
        for (int i = 0; i < 16; i++)
        begin
            sh = hi[i][4:0] + 1;
            if (sh > 11 && (a >> sh) == (hi[i] >> sh))
            begin
                win = i;
                n = sh;
            end
        end
        pm = (win < 0) ? 6'h0 : lo[win][5:0];
        b = x ? 2 : (w ? 1 : 0);
        b = s ? 5 - b : 2 - b;
        byp = a < `SPE_CTRL_LIMIT;
        ok = byp || pm[b];
        p = {4'h0, a};
        for (int k = 12; k < 36; k++)
            if (!byp && k >= n) p[k] = lo[win][k - 4];
        if (!ok) p = 36'h0;
        exc = !ok && !held;
        if (exc)
        begin
            held = 1'b1;
            fAddr = a;
            fStat = 32'h1 << b;
            iStat = 1'b1;
        end
        core_access_model_i.issue(a, w, x, s);
        @(negedge clk);
        `CHK(accValid, 1'b1)
        `CHK(accAllow, ok)
        `CHK(accFault, !ok)
        `CHK(physAddr, p)
        if (!byp) `CHK(accPerm, pm)
        `CHK(faultExc, exc)
        `CHK(irq, iStat & iMask)
        // one cycle later the answer and the pulse are gone
        @(negedge clk);
        `CHK(accValid, 1'b0)
        `CHK(physAddr, 36'h0)
        `CHK(faultExc, 1'b0)
    endtask

    // main sequence
    initial
    begin
        failCount = 0;
        nCompared = 0;
        cyc = 0;
        sysRst = 1'b1;
        avs_address = 32'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        avs_read = 1'b0;
        avs_write = 1'b0;
        held = 1'b0;
        fAddr = 32'h0;
        fStat = 32'h0;
        iStat = 1'b0;
        iMask = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            hi[i] = `SPE_ZERO_WORD;
            lo[i] = `SPE_ZERO_WORD;
        end
        hi[0] = `SPE_SEG0_HIGH;
        lo[0] = `SPE_SEG0_LOW;
        hi[1] = `SPE_SEG1_HIGH;
        lo[1] = `SPE_SEG1_LOW;
        void'($urandom(32'h2f1c4b83));
        repeat (3) @(posedge clk);
        sysRst <= 1'b0;
        // reset contents, unmapped read, pass-through map
        for (int i = 0; i < 32; i++)
            rchk(`SPE_DESC_FIRST + 4 * i, i[0] ? hi[i / 2] : lo[i / 2]);
        rchk(32'h0800_0100, 32'h0);
        rchk(`SPE_FAULT_ADDR, 32'h0);
        for (int i = 0; i < 8; i++)
            acc($urandom | 32'h1000_0000, i[0], i[1], i[2]);
        $display("test reset done");
        // every size code on the top segment, inside and just outside
        for (int c = 0; c < 32; c++)
        begin
            logic [31:0] base;
            base = $urandom | 32'hc000_0000;
            wreg(`SPE_DESC_FIRST + 32'h7c, (base & 32'hffff_f000) | c);
            wreg(`SPE_DESC_FIRST + 32'h78, $urandom);
            acc(base, 1'b0, 1'b0, 1'b1);
            acc(base ^ (32'h1 << (c + 1)), 1'b0, 1'b0, 1'b0);
        end
        $display("test sizes done");
        // each permission bit against every kind and privilege
        for (int b = 0; b < 8; b++)
        begin
            wreg(`SPE_DESC_FIRST + 32'h78, 32'h0000_0100 | (32'h1 << b));
            wreg(`SPE_DESC_FIRST + 32'h7c, 32'hd000_000b);
            for (int k = 0; k < 8; k++)
            begin
                acc(32'hd000_0abc, k[0], k[2], k[1]);
                rchk(`SPE_FAULT_STAT, fStat);
                rchk(`SPE_FAULT_ADDR, fAddr);
                wreg(`SPE_FAULT_CLR, 32'h1);
            end
        end
        $display("test permissions done");
        // no segment enabled: first fault kept, interrupt raised and cleared
        wreg(`SPE_IRQ_MASK, 32'h1);
        wreg(`SPE_DESC_FIRST + 32'h04, 32'h0);
        wreg(`SPE_DESC_FIRST + 32'h0c, 32'h0);
        wreg(`SPE_DESC_FIRST + 32'h7c, 32'h0);
        acc(32'h9000_0000, 1'b1, 1'b0, 1'b1);
        acc(32'h9100_0000, 1'b0, 1'b0, 1'b0);
        acc(32'h0bff_fffc, 1'b1, 1'b0, 1'b0);
        rchk(`SPE_FAULT_ADDR, fAddr);
        rchk(`SPE_IRQ_STAT, {31'h0, iStat});
        wreg(`SPE_IRQ_STAT, 32'h1);
        @(negedge clk);
        @(negedge clk);
        `CHK(irq, 1'b0)
        $display("test faults done");
        // random descriptors, lanes, masks, clears and accesses
        for (int r = 0; r < 400; r++)
        begin
            int s;
            int t;
            logic [31:0] v;
            s = $urandom_range(15, 0);
            t = $urandom_range(15, 0);
            v = $urandom;
            case ($urandom_range(5, 0))
                0: wreg(`SPE_DESC_FIRST + 8 * s + 4, v & 32'hffff_f01f, $urandom_range(15, 1));
                1: wreg(`SPE_DESC_FIRST + 8 * s, v, $urandom_range(15, 1));
                2: wreg(`SPE_IRQ_MASK, {31'h0, v[0]});
                3: wreg(`SPE_FAULT_CLR, v);
                4: wreg(`SPE_IRQ_STAT, v);
                default: rchk(`SPE_DESC_FIRST + 8 * s + 4, hi[s]);
            endcase
            acc({hi[t][31:12], v[11:0]} ^ (v[22] ? 32'h1 << v[27:23] : 32'h0),
                v[28], v[29], v[30]);
        end
        rchk(`SPE_FAULT_STAT, fStat);
        $display("test random done");
        wrap_up();
    end
endmodule
